// ---- hw/cic_pkg.sv ----
// Purpose: Shared constants for the CIC decimator link and its controller
// Assumes: Single clock domain, 32-bit APB register words
// Notes: Control word field positions are shared by both ends of the link
package cic_pkg;

  // Sample and accumulator widths
  localparam int IN_WIDTH = 15;
  localparam int ACC1_WIDTH = 40;
  localparam int ACC2_WIDTH = 36;
  localparam int ACC3_WIDTH = 32;
  localparam int COMB_WIDTH = 32;
  localparam int COMB_STAGES = 5;
  localparam int HB_WIDTH = 24;
  localparam int GAIN_PIN_WIDTH = 3;
  localparam int SHIFT_WIDTH = 4;
  localparam int DEC_WIDTH = 6;

  // Control word layout
  localparam int CW_BYPASS_BIT = 6;
  localparam int CW_DEC_LSB = 7;
  localparam int CW_SG_LSB = 13;
  localparam int CW_SYNC_EN_BIT = 19;
  localparam logic [3:0] SHIFT_MAX = 4'hf;
  localparam logic [31:0] CW_RESET = 32'h0000_0000;

  // Shift gain choice: floor(SG_BASE - input bits - 5*log2(R))
  localparam int SG_BASE = 39;
  localparam int INPUT_BIT_COUNT_DEFAULT = 14;

  // Decimation limit (R) for each gain offset code
  localparam logic [6:0] MAX_DEC_0 = 7'h20;
  localparam logic [6:0] MAX_DEC_1 = 7'h1b;
  localparam logic [6:0] MAX_DEC_2 = 7'h18;
  localparam logic [6:0] MAX_DEC_3 = 7'h15;
  localparam logic [6:0] MAX_DEC_4 = 7'h12;
  localparam logic [6:0] MAX_DEC_5 = 7'h10;
  localparam logic [6:0] MAX_DEC_6 = 7'h0c;
  localparam logic [6:0] MAX_DEC_7 = 7'h0a;

  // Controller register byte offsets
  localparam logic [11:0] REG_CONTROL = 12'h000;
  localparam logic [11:0] REG_SAMPLE = 12'h004;
  localparam logic [11:0] REG_GAIN = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00c;
  localparam logic [11:0] REG_OUTPUT = 12'h010;
  localparam logic [11:0] REG_EFFECTIVE = 12'h014;

  // Gain register fields
  localparam int GAIN_AUTO_SG_BIT = 4;
  localparam int GAIN_SYNC_BIT = 8;
  localparam logic [2:0] GAIN_RESET = 3'h0;

  // Status register fields
  localparam int STATUS_LEVEL_LSB = 16;
  localparam int STATUS_CLAMP_BIT = 24;

  localparam int FIFO_DEPTH = 16;

endpackage

// ---- hw/cic_link_if.sv ----
// Purpose: Link between the sample source/controller and the CIC decimator
// Assumes: Both ends clocked by the same CLK
// Notes: All signals are plain levels sampled at the rising edge
`timescale 1ns/1ps
interface cic_link_if #(parameter int OUT_WIDTH = cic_pkg::HB_WIDTH);
  logic [cic_pkg::IN_WIDTH-1:0] sample;
  logic input_sample_enable_n;
  logic [cic_pkg::GAIN_PIN_WIDTH-1:0] input_gain_offset_pins;
  logic external_sync_pin;
  logic [31:0] control_word;
  logic [OUT_WIDTH-1:0] filter_out;
  logic filter_out_valid;

  modport device
  (
    input sample,
    input input_sample_enable_n,
    input input_gain_offset_pins,
    input external_sync_pin,
    input control_word,
    output filter_out,
    output filter_out_valid
  );

  modport host
  (
    output sample,
    output input_sample_enable_n,
    output input_gain_offset_pins,
    output external_sync_pin,
    output control_word,
    input filter_out,
    input filter_out_valid
  );
endinterface

// ---- hw/sample_fifo.sv ----
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Storage is not reset; only pointers and count are
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = cic_pkg::IN_WIDTH,
  parameter int DEPTH = cic_pkg::FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad_depth
    $error("sample_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
  } fifo_state_type;

  fifo_state_type st_ff;
  fifo_state_type nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Count is one bit wider than the pointers so a full FIFO is told from an empty one
  assign in_ready = st_ff.count != (PW+1)'(DEPTH);
  assign out_valid = st_ff.count != '0;
  assign out_data = mem[st_ff.rd];
  assign level = st_ff.count;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.wr = st_ff.wr + PW'(1);
    end
    if (pop)
    begin
      nxt_st.rd = st_ff.rd + PW'(1);
    end
    if (push && !pop)
    begin
      nxt_st.count = st_ff.count + (PW+1)'(1);
    end
    else if (pop && !push)
    begin
      nxt_st.count = st_ff.count - (PW+1)'(1);
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (push)
    begin
      mem[st_ff.wr] <= in_data;
    end
  end
endmodule

// ---- hw/cic_decimator.sv ----
// Purpose: Fifth-order CIC decimator with gain barrel shifter and bypass
// Assumes: Link inputs are synchronous to CLK; control word held stable
// Notes: Output is registered; latency is two edges after the enabled sample
`timescale 1ns/1ps

// Functional notes
// - Bypass bit sends samples straight downstream.
// - Barrel shifter left-shifts sample, 6dB per step.
// - Shift is shift gain plus pins, clamped 15.
// - Gain pins pipelined alongside their own sample.
// - Five integrators at input rate, five combs decimated.
// - Decimation R-1 from control bits 12 to 7.
// - Shift gain word from control bits 16 to 13.
// - Source idles enable between samples in bypass.
// - 15-bit input; accumulators 40,36,32,32,32 bits.
// - Zero offset full-scale: decimation at most 32.
// - Each gain pin code step adds 6dB.
// - Decimation limit per gain code 32 down to 10.
// - Sync pin reloads decimation counter when enabled.
// - Shift gain chosen from input bits and R.
// - Input word is rounded 15-bit mixer product.
// - Filter advances only on enabled input cycles.
module cic_decimator #(
  parameter int OUT_WIDTH = cic_pkg::HB_WIDTH
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Link to sample source and downstream
  cic_link_if.device LNK,
  // Observation of the current gain path
  output logic [cic_pkg::SHIFT_WIDTH-1:0] SHIFT_AMOUNT,
  output logic BYPASS_ACTIVE
);
  localparam int IW = cic_pkg::IN_WIDTH;
  localparam int A1W = cic_pkg::ACC1_WIDTH;
  localparam int A2W = cic_pkg::ACC2_WIDTH;
  localparam int A3W = cic_pkg::ACC3_WIDTH;
  localparam int CW = cic_pkg::COMB_WIDTH;
  localparam int NC = cic_pkg::COMB_STAGES;
  localparam int SW = cic_pkg::SHIFT_WIDTH;
  localparam int DW = cic_pkg::DEC_WIDTH;
  localparam int GW = cic_pkg::GAIN_PIN_WIDTH;

  if (OUT_WIDTH <= IW || OUT_WIDTH > CW)
  begin : g_bad_width
    $error("cic_decimator: OUT_WIDTH must be above 15 and at most 32");
  end

  typedef struct packed {
    logic [IW-1:0] smp;
    logic [GW-1:0] gain;
    logic vld;
    logic [A1W-1:0] acc1;
    logic [A2W-1:0] acc2;
    logic [A3W-1:0] acc3;
    logic [A3W-1:0] acc4;
    logic [A3W-1:0] acc5;
    logic [DW-1:0] cnt;
    logic [NC-1:0][CW-1:0] dly;
    logic [OUT_WIDTH-1:0] out;
    logic out_vld;
    logic [SW-1:0] shift;
    logic byp;
  } cic_state_type;

  cic_state_type st_ff;
  cic_state_type nxt_st;

  // Saturating sum of programmed shift and pin offset; never wraps
  function automatic logic [SW-1:0] sat_shift(input logic [SW-1:0] sg,
                                              input logic [GW-1:0] pins);
    logic [SW:0] sum;
    sum = {1'b0, sg} + {2'b00, pins};
    if (sum > {1'b0, cic_pkg::SHIFT_MAX})
    begin
      sat_shift = cic_pkg::SHIFT_MAX;
    end
    else
    begin
      sat_shift = sum[SW-1:0];
    end
  endfunction

  logic [DW-1:0] dec_field;
  logic [SW-1:0] sg_field;
  logic bypass_bit;
  logic sync_en;
  logic [SW-1:0] shift;
  logic [A1W-1:0] shifted;
  logic [NC-1:0][CW-1:0] comb;

  assign dec_field = LNK.control_word[cic_pkg::CW_DEC_LSB +: DW];
  assign sg_field = LNK.control_word[cic_pkg::CW_SG_LSB +: SW];
  assign bypass_bit = LNK.control_word[cic_pkg::CW_BYPASS_BIT];
  assign sync_en = LNK.control_word[cic_pkg::CW_SYNC_EN_BIT];

  // Shift uses the pin code registered with this very sample
  assign shift = sat_shift(sg_field, st_ff.gain);

  // 15 input bits plus at most 15 shifts fit well inside the first accumulator
  assign shifted = {{(A1W-IW){st_ff.smp[IW-1]}}, st_ff.smp} << shift;

  // Comb chain evaluated every cycle; its result is stored only when a decimated sample is due
  always_comb
  begin
    comb = '0;
    comb[0] = st_ff.acc5 - st_ff.dly[0];
    for (int i = 1; i < NC; i++)
    begin
      comb[i] = comb[i-1] - st_ff.dly[i];
    end
  end

  always_comb
  begin
    nxt_st = st_ff;
    // Sample and its pin code enter the pipeline together
    nxt_st.vld = !LNK.input_sample_enable_n;
    nxt_st.smp = LNK.sample;
    nxt_st.gain = LNK.input_gain_offset_pins;
    nxt_st.shift = shift;
    nxt_st.byp = bypass_bit;
    nxt_st.out_vld = 1'b0;
    if (st_ff.vld)
    begin
      if (bypass_bit)
      begin
        // Raw sample goes out left-aligned, integrators frozen
        nxt_st.out = {st_ff.smp, {(OUT_WIDTH-IW){1'b0}}};
        nxt_st.out_vld = 1'b1;
      end
      else
      begin
        // Integrators wrap freely; pruned stages drop low bits
        nxt_st.acc1 = st_ff.acc1 + shifted;
        nxt_st.acc2 = st_ff.acc2 + st_ff.acc1[A1W-1 -: A2W];
        nxt_st.acc3 = st_ff.acc3 + st_ff.acc2[A2W-1 -: A3W];
        nxt_st.acc4 = st_ff.acc4 + st_ff.acc3;
        nxt_st.acc5 = st_ff.acc5 + st_ff.acc4;
        if (st_ff.cnt == '0)
        begin
          nxt_st.cnt = dec_field;
          nxt_st.dly[0] = st_ff.acc5;
          for (int i = 1; i < NC; i++)
          begin
            nxt_st.dly[i] = comb[i-1];
          end
          nxt_st.out = comb[NC-1][CW-1 -: OUT_WIDTH];
          nxt_st.out_vld = 1'b1;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - DW'(1);
        end
      end
    end
    // Sync reload wins over the free-running count so parts line up
    if (sync_en && LNK.external_sync_pin)
    begin
      nxt_st.cnt = dec_field;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign LNK.filter_out = st_ff.out;
  assign LNK.filter_out_valid = st_ff.out_vld;
  assign SHIFT_AMOUNT = st_ff.shift;
  assign BYPASS_ACTIVE = st_ff.byp;
endmodule

// ---- hw/cic_host.sv ----
// Purpose: Sample source and configuring controller for the CIC decimator
// Assumes: APB master follows the usual setup/access sequence
// Notes: Samples written over APB queue in a FIFO before the link
`timescale 1ns/1ps
module cic_host #(
  parameter int DEPTH = cic_pkg::FIFO_DEPTH,
  parameter int INPUT_BIT_COUNT = cic_pkg::INPUT_BIT_COUNT_DEFAULT,
  parameter int OUT_WIDTH = cic_pkg::HB_WIDTH
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Link to the decimator
  cic_link_if.host LNK
);
  localparam int IW = cic_pkg::IN_WIDTH;
  localparam int LW = $clog2(DEPTH) + 1;

  if (INPUT_BIT_COUNT < 1 || INPUT_BIT_COUNT > IW || LW > 8 || OUT_WIDTH > 32)
  begin : g_bad_param
    $error("cic_host: parameter out of supported range");
  end

  typedef enum logic [0:0] {FEED_OPEN = 1'b0, FEED_GAP = 1'b1} feed_type;

  typedef struct packed {
    logic [31:0] cw_raw;
    logic [31:0] cw;
    logic [2:0] gain;
    logic auto_sg;
    logic sync;
    logic [IW-1:0] smp;
    logic en_n;
    feed_type feed;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [OUT_WIDTH-1:0] last_out;
    logic [15:0] out_count;
    logic clamped;
  } host_state_type;

  host_state_type st_ff;
  host_state_type nxt_st;

  // Largest R allowed for a gain offset code
  function automatic logic [6:0] max_dec(input logic [2:0] code);
    case (code)
      3'h0: max_dec = cic_pkg::MAX_DEC_0;
      3'h1: max_dec = cic_pkg::MAX_DEC_1;
      3'h2: max_dec = cic_pkg::MAX_DEC_2;
      3'h3: max_dec = cic_pkg::MAX_DEC_3;
      3'h4: max_dec = cic_pkg::MAX_DEC_4;
      3'h5: max_dec = cic_pkg::MAX_DEC_5;
      3'h6: max_dec = cic_pkg::MAX_DEC_6;
      default: max_dec = cic_pkg::MAX_DEC_7;
    endcase
  endfunction

  // Largest s up to 15 with R^5 * 2^s <= 2^(39 - input bits)
  function automatic logic [3:0] auto_shift(input logic [5:0] field);
    logic [63:0] r5;
    logic [63:0] lim;
    logic [3:0] best;
    r5 = 64'({1'b0, field} + 7'h01);
    r5 = r5 * r5 * r5 * r5 * r5;
    lim = 64'h1 << (cic_pkg::SG_BASE - INPUT_BIT_COUNT);
    best = 4'h0;
    for (int s = 0; s < 16; s++)
    begin
      if ((r5 << s) <= lim)
      begin
        best = 4'(s);
      end
    end
    auto_shift = best;
  endfunction

  logic access;
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [IW-1:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic [5:0] raw_dec;
  logic [5:0] lim_dec;
  logic [31:0] eff_cw;

  assign access = PSEL && PENABLE && !st_ff.pready;
  assign push = access && PWRITE && PADDR == cic_pkg::REG_SAMPLE && fifo_in_ready;
  // No pop during the idle cycle that follows a bypass sample
  assign fifo_out_ready = st_ff.feed == FEED_OPEN;

  sample_fifo #(.WIDTH(IW), .DEPTH(DEPTH)) u_fifo
  (
    .CLK(CLK),
    .RST(RST),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(PWDATA[IW-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Effective control word: decimation clamped for gain code, optional auto shift
  always_comb
  begin
    raw_dec = st_ff.cw_raw[cic_pkg::CW_DEC_LSB +: 6];
    lim_dec = 6'(max_dec(st_ff.gain) - 7'h01);
    eff_cw = st_ff.cw_raw;
    if (raw_dec > lim_dec)
    begin
      eff_cw[cic_pkg::CW_DEC_LSB +: 6] = lim_dec;
    end
    if (st_ff.auto_sg)
    begin
      eff_cw[cic_pkg::CW_SG_LSB +: 4] = auto_shift(eff_cw[cic_pkg::CW_DEC_LSB +: 6]);
    end
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.cw = eff_cw;
    nxt_st.clamped = raw_dec > lim_dec;
    nxt_st.sync = 1'b0;
    nxt_st.en_n = 1'b1;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    case (st_ff.feed)
      FEED_GAP: nxt_st.feed = FEED_OPEN;
      default: nxt_st.feed = FEED_OPEN;
    endcase
    if (fifo_out_valid && fifo_out_ready)
    begin
      nxt_st.smp = fifo_out_data;
      nxt_st.en_n = 1'b0;
      if (st_ff.cw[cic_pkg::CW_BYPASS_BIT])
      begin
        nxt_st.feed = FEED_GAP;
      end
    end
    if (LNK.filter_out_valid)
    begin
      nxt_st.last_out = LNK.filter_out;
      nxt_st.out_count = st_ff.out_count + 16'h0001;
    end
    // A sample write waits in the access phase while the FIFO is full
    if (access && !(PWRITE && PADDR == cic_pkg::REG_SAMPLE && !fifo_in_ready))
    begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h0000_0000;
      case (PADDR)
        cic_pkg::REG_CONTROL:
        begin
          if (PWRITE)
          begin
            nxt_st.cw_raw = PWDATA;
          end
          nxt_st.prdata = st_ff.cw_raw;
        end
        cic_pkg::REG_SAMPLE: nxt_st.prdata = 32'h0000_0000;
        cic_pkg::REG_GAIN:
        begin
          if (PWRITE)
          begin
            nxt_st.gain = PWDATA[2:0];
            nxt_st.auto_sg = PWDATA[cic_pkg::GAIN_AUTO_SG_BIT];
            nxt_st.sync = PWDATA[cic_pkg::GAIN_SYNC_BIT];
          end
          nxt_st.prdata[2:0] = st_ff.gain;
          nxt_st.prdata[cic_pkg::GAIN_AUTO_SG_BIT] = st_ff.auto_sg;
        end
        cic_pkg::REG_STATUS:
        begin
          nxt_st.prdata[15:0] = st_ff.out_count;
          nxt_st.prdata[cic_pkg::STATUS_LEVEL_LSB +: 8] = 8'(fifo_level);
          nxt_st.prdata[cic_pkg::STATUS_CLAMP_BIT] = st_ff.clamped;
        end
        cic_pkg::REG_OUTPUT: nxt_st.prdata[OUT_WIDTH-1:0] = st_ff.last_out;
        cic_pkg::REG_EFFECTIVE: nxt_st.prdata = st_ff.cw;
        default: nxt_st.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_ff <= '0;
      st_ff.cw_raw <= cic_pkg::CW_RESET;
      st_ff.cw <= cic_pkg::CW_RESET;
      st_ff.gain <= cic_pkg::GAIN_RESET;
      st_ff.en_n <= 1'b1;
      st_ff.feed <= FEED_OPEN;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign PRDATA = st_ff.prdata;
  assign PREADY = st_ff.pready;
  assign PSLVERR = st_ff.pslverr;
  assign LNK.sample = st_ff.smp;
  assign LNK.input_sample_enable_n = st_ff.en_n;
  assign LNK.input_gain_offset_pins = st_ff.gain;
  assign LNK.external_sync_pin = st_ff.sync;
  assign LNK.control_word = st_ff.cw;
endmodule

// ---- verif/cic_link_monitor.sv ----
// Purpose: Concurrent checks on the link between host and decimator
// Assumes: One clock, RST asynchronous active high
// Notes: Helpers line up enabled samples with outputs two edges later
`timescale 1ns/1ps
module cic_link_monitor (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Link signals
  input wire logic [cic_pkg::IN_WIDTH-1:0] sample,
  input wire logic input_sample_enable_n,
  input wire logic [cic_pkg::GAIN_PIN_WIDTH-1:0] input_gain_offset_pins,
  input wire logic external_sync_pin,
  input wire logic [31:0] control_word,
  input wire logic [cic_pkg::HB_WIDTH-1:0] filter_out,
  input wire logic filter_out_valid,
  // Decimator observation
  input wire logic [cic_pkg::SHIFT_WIDTH-1:0] SHIFT_AMOUNT,
  input wire logic BYPASS_ACTIVE
);
  localparam logic [5:0] LIM [8] = '{6'h1f, 6'h1a, 6'h17, 6'h14, 6'h11, 6'h0f, 6'h0b, 6'h09};
  logic en_d1, en_d2, sy_d1, sy_d2, first;
  logic [5:0] since;

  function automatic logic [3:0] sat(input logic [3:0] g, input logic [2:0] p);
    logic [4:0] s;
    s = {1'b0, g} + {2'b00, p};
    return (s > 5'h0f) ? 4'hf : s[3:0];
  endfunction

  // Sync is delayed like samples so both meet the output timeline
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      {en_d1, en_d2, sy_d1, sy_d2} <= 4'h0;
      first <= 1'b1;
      since <= 6'h00;
    end
    else
    begin
      en_d1 <= !input_sample_enable_n;
      en_d2 <= en_d1;
      sy_d1 <= external_sync_pin && control_word[19];
      sy_d2 <= sy_d1;
      if (sy_d2 || (en_d2 && !BYPASS_ACTIVE && filter_out_valid))
      begin
        since <= 6'h00;
        first <= 1'b0;
      end
      else if (en_d2 && !BYPASS_ACTIVE)
        since <= since + 6'h01;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  property p_bypass_data;
    (!input_sample_enable_n && control_word[6] && BYPASS_ACTIVE) |=> ##1
      (filter_out_valid && filter_out == {$past(sample, 2), 9'h000});
  endproperty
  a_bypass_data: assert property (p_bypass_data)
    else $error("bypass output wrong");

  property p_shift_sum;
    !input_sample_enable_n |=>
      SHIFT_AMOUNT == sat($past(control_word[16:13]), $past(input_gain_offset_pins));
  endproperty
  a_shift_sum: assert property (p_shift_sum)
    else $error("shift amount wrong");

  property p_dec_ratio;
    (en_d2 && !BYPASS_ACTIVE) |-> filter_out_valid == (first || since == control_word[12:7]);
  endproperty
  a_dec_ratio: assert property (p_dec_ratio)
    else $error("decimation ratio wrong");

  property p_valid_cause;
    filter_out_valid |-> en_d2;
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("output without enabled sample");

  property p_bypass_gap;
    (control_word[6] && !input_sample_enable_n) |=> input_sample_enable_n;
  endproperty
  a_bypass_gap: assert property (p_bypass_gap)
    else $error("no idle cycle between bypass samples");

  property p_out_hold;
    !filter_out_valid |-> $stable(filter_out);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output changed without strobe");

  property p_sync_pulse;
    $rose(external_sync_pin) |=> !external_sync_pin;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync longer than one cycle");

  property p_clamp;
    $stable(input_gain_offset_pins) |-> control_word[12:7] <= LIM[input_gain_offset_pins];
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("decimation above limit");
endmodule

// ---- verif/test_cic_decimation_filter.sv ----
// Purpose: Self-checking bench for the decimator and its host
// Assumes: APB master with setup and access phases, 40 MHz clock
// Notes: Bit 24 of a queued note marks a value to compare
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module test_cic_decimation_filter;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, bypass_active;
  logic [3:0] shift_amount;
  logic [24:0] e;
  logic [24:0] exp_q[$];
  logic [5:0] rs [3] = '{6'h00, 6'h05, 6'h09};
  int err_count = 0;
  int total_checks = 0;

  always #12.5 clk = ~clk;

  cic_link_if lnk();
  cic_host cic_host_inst (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LNK(lnk.host));
  cic_decimator cic_decimator_inst (.CLK(clk), .RST(rst), .LNK(lnk.device),
    .SHIFT_AMOUNT(shift_amount), .BYPASS_ACTIVE(bypass_active));
  cic_link_monitor cic_link_monitor_inst (.CLK(clk), .RST(rst), .sample(lnk.sample),
    .input_sample_enable_n(lnk.input_sample_enable_n),
    .input_gain_offset_pins(lnk.input_gain_offset_pins),
    .external_sync_pin(lnk.external_sync_pin), .control_word(lnk.control_word),
    .filter_out(lnk.filter_out), .filter_out_valid(lnk.filter_out_valid),
    .SHIFT_AMOUNT(shift_amount), .BYPASS_ACTIVE(bypass_active));

  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Entered just after a rising edge; one idle edge at the end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cfg(input logic byp, input logic [5:0] r1, input logic [3:0] sg,
    input logic [2:0] pins, input logic sy);
    apb(1'b1, cic_pkg::REG_GAIN, {29'h0, pins});
    apb(1'b1, cic_pkg::REG_CONTROL, {12'h000, 1'b1, 2'b00, sg, r1, byp, 6'h00});
    if (sy)
      apb(1'b1, cic_pkg::REG_GAIN, {23'h0, 1'b1, 5'h00, pins});
  endtask

  // The note goes in first: the output can beat the APB handshake
  task automatic samp(input logic [14:0] v, input logic chk);
    if (chk)
      exp_q.push_back({1'b1, v, 9'h000});
    apb(1'b1, cic_pkg::REG_SAMPLE, {17'h0, v});
  endtask

  always @(posedge clk)
  begin
    if (!rst && lnk.filter_out_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        `CHK(1'b1, 1'b0)
      else
      begin
        e = exp_q.pop_front();
        if (e[24])
          `CHK(lnk.filter_out, e[23:0])
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial
  begin
    void'($urandom(37));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // DC level: 3 shifted by 8 at R=4 settles to 12 after five outputs
    for (int k = 0; k < 2; k++)
    begin
      cfg(1'b0, 6'h03, (k == 0) ? 4'h8 : 4'h5, (k == 0) ? 3'h0 : 3'h3, 1'b0);
      repeat (6) exp_q.push_back(25'h0);
      repeat (4) exp_q.push_back({1'b1, 24'h00000c});
      repeat (40) samp(15'h0003, 1'b0);
    end
    $display("dc gain test done");
    for (int c = 0; c < 8; c++)
    begin
      cfg(1'b1, 6'h03, (c == 7) ? 4'hf : 4'($urandom), 3'(c), 1'b0);
      repeat (2) samp(15'($urandom), 1'b1);
    end
    $display("bypass and shift test done");
    // Two outputs from 2R samples once sync has reloaded the count; R=1 outputs every sample
    foreach (rs[i])
    begin
      cfg(1'b0, rs[i], 4'($urandom), 3'h0, 1'b1);
      repeat (2) exp_q.push_back(25'h0);
      repeat (2 * rs[i] + 2) samp(15'($urandom), 1'b0);
    end
    $display("decimation and sync test done");
    cfg(1'b0, 6'h3f, 4'h0, 3'h7, 1'b0);
    apb(1'b0, cic_pkg::REG_EFFECTIVE, 32'h0);
    `CHK(rd[12:7], 6'h09)
    apb(1'b0, cic_pkg::REG_STATUS, 32'h0);
    `CHK(rd[24], 1'b1)
    `CHK(rd[23:16], 8'h00)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    $display("register test done");
    repeat (20) @(posedge clk);
    `CHK(exp_q.size(), 0)
    close_out();
  end
endmodule
